// File: rtl/bcr_pkg.sv
// Shared constants and types for the buck configuration register bank
package bcr_pkg;

  // Register byte addresses on the register access port
  localparam logic [7:0] BCR_ADDR_ILIM  = 8'h9C;
  localparam logic [7:0] BCR_ADDR_CORE2 = 8'h9D;
  localparam logic [7:0] BCR_ADDR_CORE1 = 8'h9E;
  localparam logic [7:0] BCR_ADDR_TERM  = 8'h9F;

  // Field positions
  localparam int BCR_ILIM2_LSB   = 4;
  localparam int BCR_ILIM1_LSB   = 0;
  localparam int BCR_ILIM_W      = 4;
  localparam int BCR_MODE_LSB    = 6;
  localparam int BCR_PD_BIT      = 5;
  localparam int BCR_TRACK_BIT   = 4;
  localparam int BCR_HALFREF_BIT = 3;
  localparam int BCR_SENSE_LSB   = 0;
  localparam int BCR_SENSE_W     = 3;

  // Writable bits per register; reserved bits 4:3 of the core configs stay zero
  localparam logic [7:0] BCR_CORE_MASK = 8'hE7;
  localparam logic [7:0] BCR_TERM_MASK = 8'hFF;

  // Values after reset
  localparam logic [7:0] BCR_RST_ILIM = 8'h00;
  localparam logic [7:0] BCR_RST_CONF = 8'h01;

  // Current limit scale in mA
  localparam logic [11:0] BCR_LIM_BASE_MA = 12'h1F4;
  localparam logic [11:0] BCR_LIM_STEP_MA = 12'h064;

  // Buck indices
  localparam int BCR_NUM_BUCKS = 3;
  localparam int BCR_CORE2     = 0;
  localparam int BCR_CORE1     = 1;
  localparam int BCR_TERM      = 2;

  typedef enum logic [1:0] {
    BCR_OP_VREG  = 2'h0,
    BCR_OP_SLEEP = 2'h1,
    BCR_OP_SYNC  = 2'h2,
    BCR_OP_AUTO  = 2'h3
  } bcr_op_e;

  function automatic logic [11:0] bcr_limit_ma(input logic [3:0] code, input logic full);
    logic [11:0] base;
    base = BCR_LIM_BASE_MA + BCR_LIM_STEP_MA * {8'h00, code};
    return full ? {base[10:0], 1'b0} : base;
  endfunction

endpackage

// File: rtl/bcr_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module bcr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // First stage feeds only the second stage
  always_comb begin
    next_meta     = ce ? async_in : meta;
    next_sync_out = ce ? meta : sync_out;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule

// File: rtl/bcr_mode_decode.sv
// Operation-select decode for one buck
`timescale 1ns/100ps
module bcr_mode_decode (
  input  wire logic [1:0] op_select,
  input  wire logic       vreg_sleep,
  output logic            op_sleep,
  output logic            op_sync,
  output logic            op_auto
);
  import bcr_pkg::*;

  // All four codes are legal, so no default item
  always_comb begin
    op_sleep = 1'b0;
    op_sync  = 1'b0;
    op_auto  = 1'b0;
    unique case (bcr_op_e'(op_select))
      BCR_OP_VREG: begin
        op_sleep = vreg_sleep;
        op_sync  = ~vreg_sleep;
      end
      BCR_OP_SLEEP: op_sleep = 1'b1;
      BCR_OP_SYNC:  op_sync  = 1'b1;
      BCR_OP_AUTO:  op_auto  = 1'b1;
    endcase
  end
endmodule

// File: rtl/bcr_top.sv
// Configuration register bank for two core bucks and the termination-capable buck
`timescale 1ns/100ps
// What this block does
// - Bits 7:4 of limits register give second core limit, 500-2000 mA, doubled at full current.
// - Bits 3:0 of limits register give first core limit, same scale and doubling.
// - Second core mode: 00 voltage register, 01 sleep, 10 synchronous, 11 automatic.
// - First core mode uses the same four codes.
// - Termination buck mode uses the same four codes.
// - Second core pull-down on when bit 5 is 0, always off in dual-phase.
// - Bit 5 set removes first core or termination buck pull-down while disabled.
// - Second core sense bits each add own output, core or peripheral switch node.
// - First core code 000 senses own output, or remote differential sensing when merged.
// - First core sense bits combine sources; 000 turns off the sense mixer.
// - Termination buck sense bits combine own output, core and peripheral nodes.
// - Bit 4 makes termination buck track half the memory supply sense voltage.
// - Bit 3 low: comparator input and general input status; high: half reference out.
// - In voltage-register mode, bit 7 of active voltage register picks sleep or sync.
module bcr_top
  import bcr_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic                         full_current_mode,
  input  wire logic                         core_bucks_merged,
  input  wire logic                         dual_phase_active,
  input  wire logic [bcr_pkg::BCR_NUM_BUCKS-1:0] vreg_sleep,
  input  wire logic                         memory_supply_sense_port,
  output logic      [11:0]                  second_core_current_limit,
  output logic      [11:0]                  first_core_current_limit,
  output logic      [bcr_pkg::BCR_NUM_BUCKS-1:0] buck_sleep,
  output logic      [bcr_pkg::BCR_NUM_BUCKS-1:0] buck_sync,
  output logic      [bcr_pkg::BCR_NUM_BUCKS-1:0] buck_auto,
  output logic      [bcr_pkg::BCR_NUM_BUCKS-1:0] buck_pulldown_on,
  output logic      [2:0]                   second_core_sense_select,
  output logic      [2:0]                   first_core_sense_select,
  output logic                              first_core_mixer_on,
  output logic                              first_core_remote_diff_sense,
  output logic      [2:0]                   termination_buck_sense_select,
  output logic                              termination_tracking_enable,
  output logic                              half_reference_output_enable,
  output logic                              comparator_input_function,
  output logic                              general_input_status_function
);
  import bcr_pkg::*;

  // Register state
  logic [7:0] ilim;
  logic [7:0] conf [BCR_NUM_BUCKS];
  logic [7:0] next_ilim;
  logic [7:0] next_conf [BCR_NUM_BUCKS];
  logic [7:0] next_reg_rdata;
  logic       next_reg_rvalid;
  logic [7:0] conf_mask [BCR_NUM_BUCKS];
  logic [7:0] conf_addr [BCR_NUM_BUCKS];

  // Decoded outputs
  logic [11:0] next_second_limit;
  logic [11:0] next_first_limit;
  logic [BCR_NUM_BUCKS-1:0] dec_sleep;
  logic [BCR_NUM_BUCKS-1:0] dec_sync;
  logic [BCR_NUM_BUCKS-1:0] dec_auto;
  logic [BCR_NUM_BUCKS-1:0] next_pulldown;
  logic [2:0]  next_second_sense;
  logic [2:0]  next_first_sense;
  logic        next_mixer_on;
  logic        next_remote_diff;
  logic [2:0]  next_term_sense;
  logic        next_tracking;
  logic        next_halfref;
  logic        next_comparator;
  logic        next_gpi;
  logic        gpi_pin_sync;
  logic [2:0]  first_code;

  assign conf_mask[BCR_CORE2] = BCR_CORE_MASK;
  assign conf_mask[BCR_CORE1] = BCR_CORE_MASK;
  assign conf_mask[BCR_TERM]  = BCR_TERM_MASK;
  assign conf_addr[BCR_CORE2] = BCR_ADDR_CORE2;
  assign conf_addr[BCR_CORE1] = BCR_ADDR_CORE1;
  assign conf_addr[BCR_TERM]  = BCR_ADDR_TERM;

  // Memory supply port status arrives from a pin
  bcr_sync #(
    .WIDTH (1)
  ) u_gpi_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in (memory_supply_sense_port),
    .sync_out (gpi_pin_sync)
  );

  // Register writes and reads
  always_comb begin
    next_ilim       = ilim;
    next_reg_rdata  = reg_rdata;
    next_reg_rvalid = 1'b0;
    for (int i = 0; i < BCR_NUM_BUCKS; i++) begin
      next_conf[i] = conf[i];
    end
    if (ce) begin
      if (reg_wr && reg_addr == BCR_ADDR_ILIM) begin
        next_ilim = reg_wdata;
      end
      for (int i = 0; i < BCR_NUM_BUCKS; i++) begin
        if (reg_wr && reg_addr == conf_addr[i]) begin
          next_conf[i] = reg_wdata & conf_mask[i];
        end
      end
      if (reg_rd) begin
        next_reg_rvalid = 1'b1;
        // Unmapped addresses read as zero
        next_reg_rdata  = 8'h00;
        if (reg_addr == BCR_ADDR_ILIM) begin
          next_reg_rdata = ilim;
        end
        for (int i = 0; i < BCR_NUM_BUCKS; i++) begin
          if (reg_addr == conf_addr[i]) begin
            next_reg_rdata = conf[i];
          end
        end
      end
    end else begin
      next_reg_rvalid = reg_rvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ilim       <= BCR_RST_ILIM;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
      for (int i = 0; i < BCR_NUM_BUCKS; i++) begin
        conf[i] <= BCR_RST_CONF;
      end
    end else begin
      ilim       <= next_ilim;
      reg_rdata  <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      for (int i = 0; i < BCR_NUM_BUCKS; i++) begin
        conf[i] <= next_conf[i];
      end
    end
  end

  // One operation decoder per buck
  for (genvar g = 0; g < BCR_NUM_BUCKS; g++) begin : g_mode
    logic [1:0] op_field;
    assign op_field = conf[g][BCR_MODE_LSB +: 2];
    // Separate decoder per buck keeps each buck's voltage-register bit on its own index
    bcr_mode_decode u_mode_decode (
      .op_select  (op_field),
      .vreg_sleep (vreg_sleep[g]),
      .op_sleep   (dec_sleep[g]),
      .op_sync    (dec_sync[g]),
      .op_auto    (dec_auto[g])
    );
  end

  // Analog control decode
  always_comb begin
    first_code        = conf[BCR_CORE1][BCR_SENSE_LSB +: BCR_SENSE_W];
    next_second_limit = bcr_limit_ma(ilim[BCR_ILIM2_LSB +: BCR_ILIM_W], full_current_mode);
    next_first_limit  = bcr_limit_ma(ilim[BCR_ILIM1_LSB +: BCR_ILIM_W], full_current_mode);
    // Dual-phase overrides the second core pull-down regardless of the bit
    next_pulldown[BCR_CORE2] = ~conf[BCR_CORE2][BCR_PD_BIT] & ~dual_phase_active;
    next_pulldown[BCR_CORE1] = ~conf[BCR_CORE1][BCR_PD_BIT];
    next_pulldown[BCR_TERM]  = ~conf[BCR_TERM][BCR_PD_BIT];
    // Code 000 is passed on unchanged; software must not write it
    next_second_sense = conf[BCR_CORE2][BCR_SENSE_LSB +: BCR_SENSE_W];
    next_term_sense   = conf[BCR_TERM][BCR_SENSE_LSB +: BCR_SENSE_W];
    next_mixer_on     = first_code != 3'h0;
    next_remote_diff  = first_code == 3'h0 && core_bucks_merged;
    next_first_sense  = first_code;
    if (first_code == 3'h0 && !core_bucks_merged) begin
      next_first_sense = 3'h1;
    end
    next_tracking   = conf[BCR_TERM][BCR_TRACK_BIT];
    next_halfref    = conf[BCR_TERM][BCR_HALFREF_BIT];
    next_comparator = ~conf[BCR_TERM][BCR_HALFREF_BIT];
    next_gpi        = ~conf[BCR_TERM][BCR_HALFREF_BIT] & gpi_pin_sync;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      second_core_current_limit     <= BCR_LIM_BASE_MA;
      first_core_current_limit      <= BCR_LIM_BASE_MA;
      buck_sleep                    <= '0;
      buck_sync                     <= '0;
      buck_auto                     <= '0;
      buck_pulldown_on              <= '0;
      second_core_sense_select      <= 3'h0;
      first_core_sense_select       <= 3'h0;
      first_core_mixer_on           <= 1'b0;
      first_core_remote_diff_sense  <= 1'b0;
      termination_buck_sense_select <= 3'h0;
      termination_tracking_enable   <= 1'b0;
      half_reference_output_enable  <= 1'b0;
      comparator_input_function     <= 1'b0;
      general_input_status_function <= 1'b0;
    end else if (ce) begin
      second_core_current_limit     <= next_second_limit;
      first_core_current_limit      <= next_first_limit;
      buck_sleep                    <= dec_sleep;
      buck_sync                     <= dec_sync;
      buck_auto                     <= dec_auto;
      buck_pulldown_on              <= next_pulldown;
      second_core_sense_select      <= next_second_sense;
      first_core_sense_select       <= next_first_sense;
      first_core_mixer_on           <= next_mixer_on;
      first_core_remote_diff_sense  <= next_remote_diff;
      termination_buck_sense_select <= next_term_sense;
      termination_tracking_enable   <= next_tracking;
      half_reference_output_enable  <= next_halfref;
      comparator_input_function     <= next_comparator;
      general_input_status_function <= next_gpi;
    end
  end

  // Checks; a frozen cycle abandons any attempt in flight
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  core2_limit_a: assert property (
    ce |=> second_core_current_limit ==
      bcr_limit_ma($past(ilim[7:4]), $past(full_current_mode)))
    else $error("second core current limit wrong");

  core1_limit_a: assert property (
    reg_wr && reg_addr == BCR_ADDR_ILIM ##1 ce |=>
      first_core_current_limit ==
        bcr_limit_ma($past(reg_wdata[3:0], 2), $past(full_current_mode)))
    else $error("first core current limit not taken from write");

  core2_sleep_a: assert property (
    conf[BCR_CORE2][7:6] == 2'h1 |=> buck_sleep[BCR_CORE2] && !buck_sync[BCR_CORE2]
      && !buck_auto[BCR_CORE2])
    else $error("second core forced sleep not decoded");

  core1_sync_a: assert property (
    conf[BCR_CORE1][7:6] == 2'h2 |=> $onehot({buck_sync[BCR_CORE1], buck_sleep[BCR_CORE1],
      buck_auto[BCR_CORE1]}) && buck_sync[BCR_CORE1])
    else $error("first core forced sync not decoded");

  term_auto_a: assert property (
    conf[BCR_TERM][7:6] == 2'h3 |=> buck_auto[BCR_TERM] && !buck_sleep[BCR_TERM])
    else $error("termination buck auto not decoded");

  vreg_follow_a: assert property (
    conf[BCR_TERM][7:6] == 2'h0 |=> buck_sleep[BCR_TERM] == $past(vreg_sleep[BCR_TERM])
      && buck_sync[BCR_TERM] != buck_sleep[BCR_TERM])
    else $error("voltage register sleep bit not followed");

  core2_pulldown_a: assert property (
    dual_phase_active || conf[BCR_CORE2][5] |=> !buck_pulldown_on[BCR_CORE2])
    else $error("second core pull-down on in dual-phase or disabled");

  pulldown_off_a: assert property (
    ce |=> buck_pulldown_on[BCR_CORE1] == !$past(conf[BCR_CORE1][5])
      && buck_pulldown_on[BCR_TERM] == !$past(conf[BCR_TERM][5]))
    else $error("pull-down disable bit not applied");

  core2_sense_a: assert property (
    ce |=> second_core_sense_select == $past(conf[BCR_CORE2][2:0]))
    else $error("second core sense select mismatch");

  core1_fallback_a: assert property (
    conf[BCR_CORE1][2:0] == 3'h0 |=> !first_core_mixer_on
      && first_core_remote_diff_sense == $past(core_bucks_merged))
    else $error("first core 000 sense handling wrong");

  core1_mixer_a: assert property (
    conf[BCR_CORE1][2:0] != 3'h0 |=> first_core_mixer_on
      && first_core_sense_select == $past(conf[BCR_CORE1][2:0]))
    else $error("first core sense mixer not on");

  term_track_a: assert property (
    $rose(conf[BCR_TERM][4]) |=> termination_tracking_enable)
    else $error("tracking enable not applied");

  halfref_a: assert property (
    conf[BCR_TERM][3] |=> half_reference_output_enable && !comparator_input_function
      && !general_input_status_function)
    else $error("half reference port function wrong");

  reserved_zero_a: assert property (
    reg_rd && (reg_addr == BCR_ADDR_CORE1 || reg_addr == BCR_ADDR_CORE2)
      |=> reg_rvalid && reg_rdata[4:3] == 2'h0)
    else $error("reserved bits read non-zero");

  ilim_write_c:   cover property (reg_wr && reg_addr == BCR_ADDR_ILIM ##2 full_current_mode);
  tracking_c:     cover property (termination_tracking_enable && half_reference_output_enable);
  merged_sense_c: cover property (first_core_remote_diff_sense);
  dual_phase_c:   cover property (dual_phase_active ##1 !buck_pulldown_on[BCR_CORE2]);
endmodule

// File: dv/test_bcr_top.sv
// Self-checking testbench for the buck configuration register bank
`timescale 1ns/100ps
module test_bcr_top;
  import bcr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        full_current_mode = 1'b0;
  logic        core_bucks_merged = 1'b0;
  logic        dual_phase_active = 1'b0;
  logic [2:0]  vreg_sleep = 3'h0;
  logic        memory_supply_sense_port = 1'b0;
  logic [11:0] lim2;
  logic [11:0] lim1;
  logic [2:0]  buck_sleep;
  logic [2:0]  buck_sync;
  logic [2:0]  buck_auto;
  logic [2:0]  buck_pulldown_on;
  logic [2:0]  sense2;
  logic [2:0]  sense1;
  logic        mixer_on;
  logic        remote_diff;
  logic [2:0]  sense_term;
  logic        tracking;
  logic        half_ref;
  logic        cmp_fn;
  logic        gpi_fn;
  int          mismatches = 0;
  int          checked = 0;

  always #5 clk = ~clk;

  bcr_top i_bcr_top (
    .clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .full_current_mode(full_current_mode),
    .core_bucks_merged(core_bucks_merged), .dual_phase_active(dual_phase_active),
    .vreg_sleep(vreg_sleep), .memory_supply_sense_port(memory_supply_sense_port),
    .second_core_current_limit(lim2), .first_core_current_limit(lim1),
    .buck_sleep(buck_sleep), .buck_sync(buck_sync), .buck_auto(buck_auto),
    .buck_pulldown_on(buck_pulldown_on), .second_core_sense_select(sense2),
    .first_core_sense_select(sense1), .first_core_mixer_on(mixer_on),
    .first_core_remote_diff_sense(remote_diff), .termination_buck_sense_select(sense_term),
    .termination_tracking_enable(tracking), .half_reference_output_enable(half_ref),
    .comparator_input_function(cmp_fn), .general_input_status_function(gpi_fn)
  );

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // All driving happens 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Returns two edges after the write edge, when decoded outputs have settled
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    tick(1);
    reg_wr = 1'b0;
    tick(2);
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    int n;
    reg_rd = 1'b1;
    reg_addr = addr;
    tick(1);
    reg_rd = 1'b0;
    check("read valid", 12'(reg_rvalid), 12'h001);
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      mismatches++;
      complete_run();
    end
    check("read data", 12'(reg_rdata), 12'(exp));
    tick(1);
    check("valid pulse", 12'(reg_rvalid), 12'h000);
  endtask

  function automatic logic [11:0] lim_ma(input int code, input logic full);
    int ma;
    ma = 500 + 100 * code;
    return full ? 12'(2 * ma) : 12'(ma);
  endfunction

  task automatic do_reset();
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(2);
  endtask

  task automatic test_reset_values();
    check("limit two", lim2, 12'h1F4);
    check("limit one", lim1, 12'h1F4);
    check("pulldowns", 12'(buck_pulldown_on), 12'h007);
    check("sense two", 12'(sense2), 12'h001);
    check("sense one", 12'(sense1), 12'h001);
    check("sense term", 12'(sense_term), 12'h001);
    check("comparator", 12'(cmp_fn), 12'h001);
    rdc(BCR_ADDR_ILIM, 8'h00);
    rdc(BCR_ADDR_CORE2, 8'h01);
    rdc(BCR_ADDR_CORE1, 8'h01);
    rdc(BCR_ADDR_TERM, 8'h01);
  endtask

  task automatic test_limits();
    for (int c = 0; c < 16; c++) begin
      wr(BCR_ADDR_ILIM, {4'(15 - c), 4'(c)});
      check("limit two", lim2, lim_ma(15 - c, 1'b0));
      check("limit one", lim1, lim_ma(c, 1'b0));
      full_current_mode = 1'b1;
      tick(1);
      check("limit two full", lim2, lim_ma(15 - c, 1'b1));
      check("limit one full", lim1, lim_ma(c, 1'b1));
      full_current_mode = 1'b0;
    end
    rdc(BCR_ADDR_ILIM, 8'h0F);
  endtask

  task automatic test_modes();
    logic [2:0] e_sl;
    logic [2:0] e_sy;
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 2; v++) begin
        // Alternating per-buck pattern catches the first core index swapped with another buck's
        vreg_sleep = (v == 1) ? 3'h5 : 3'h2;
        wr(BCR_ADDR_CORE2, {2'(m), 6'h01});
        wr(BCR_ADDR_CORE1, {2'(m), 6'h01});
        wr(BCR_ADDR_TERM, {2'(m), 6'h01});
        e_sl = (m == 1) ? 3'h7 : (m == 0) ? vreg_sleep : 3'h0;
        e_sy = (m == 2) ? 3'h7 : (m == 0) ? ~vreg_sleep : 3'h0;
        check("sleep", 12'(buck_sleep), 12'(e_sl));
        check("sync", 12'(buck_sync), 12'(e_sy));
        check("auto", 12'(buck_auto), (m == 3) ? 12'h007 : 12'h000);
      end
    end
  endtask

  task automatic test_pulldown();
    wr(BCR_ADDR_CORE2, 8'hFF);
    wr(BCR_ADDR_CORE1, 8'h3A);
    wr(BCR_ADDR_TERM, 8'h3A);
    rdc(BCR_ADDR_CORE2, 8'hE7);
    rdc(BCR_ADDR_CORE1, 8'h22);
    rdc(BCR_ADDR_TERM, 8'h3A);
    check("pulldowns off", 12'(buck_pulldown_on), 12'h000);
    wr(BCR_ADDR_CORE2, 8'h01);
    wr(BCR_ADDR_CORE1, 8'h01);
    wr(BCR_ADDR_TERM, 8'h01);
    check("pulldowns on", 12'(buck_pulldown_on), 12'h007);
    dual_phase_active = 1'b1;
    tick(1);
    check("pulldowns dual", 12'(buck_pulldown_on), 12'h006);
    dual_phase_active = 1'b0;
    tick(1);
    check("pulldowns single", 12'(buck_pulldown_on), 12'h007);
  endtask

  task automatic test_sense();
    for (int s = 0; s < 8; s++) begin
      for (int mg = 0; mg < 2; mg++) begin
        core_bucks_merged = mg[0];
        // Second core never gets the invalid empty selection
        wr(BCR_ADDR_CORE2, {5'h00, (s == 0) ? 3'h1 : 3'(s)});
        wr(BCR_ADDR_CORE1, {5'h00, 3'(s)});
        wr(BCR_ADDR_TERM, {5'h00, 3'(s)});
        check("sense two", 12'(sense2), (s == 0) ? 12'h001 : 12'(s));
        check("sense one", 12'(sense1), (s == 0 && mg == 0) ? 12'h001 : 12'(s));
        check("mixer", 12'(mixer_on), 12'(s != 0));
        check("remote diff", 12'(remote_diff), 12'(s == 0 && mg == 1));
        check("sense term", 12'(sense_term), 12'(s));
      end
    end
    core_bucks_merged = 1'b0;
  endtask

  task automatic test_tracking();
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 2; p++) begin
        memory_supply_sense_port = p[0];
        // Tracking is only ever set together with the reference enable
        wr(BCR_ADDR_TERM, {3'h0, (k == 0) ? 2'h0 : (k == 1) ? 2'h1 : 2'h3, 3'h1});
        tick(2);
        check("tracking", 12'(tracking), 12'(k == 2));
        check("half ref", 12'(half_ref), 12'(k != 0));
        check("comparator", 12'(cmp_fn), 12'(k == 0));
        check("input status", 12'(gpi_fn), 12'(k == 0 && p == 1));
      end
    end
  endtask

  task automatic test_access();
    wr(BCR_ADDR_ILIM, 8'h5A);
    wr(8'hA0, 8'hC3);
    rdc(8'hA0, 8'h00);
    rdc(BCR_ADDR_ILIM, 8'h5A);
    ce = 1'b0;
    wr(BCR_ADDR_ILIM, 8'h11);
    ce = 1'b1;
    rdc(BCR_ADDR_ILIM, 8'h5A);
    check("frozen limit", lim2, lim_ma(5, 1'b0));
    // Read and write in one cycle returns the old value
    reg_wr = 1'b1;
    reg_wdata = 8'h96;
    rdc(BCR_ADDR_ILIM, 8'h5A);
    reg_wr = 1'b0;
    rdc(BCR_ADDR_ILIM, 8'h96);
  endtask

  initial begin
    do_reset();
    test_reset_values();
    test_limits();
    test_modes();
    test_pulldown();
    test_sense();
    test_tracking();
    test_access();
    do_reset();
    test_reset_values();
    complete_run();
  end
endmodule
